// ### spp_pole_ident.sv
// How it works
// (R1) Mode-launched identification ends with inverter disabled
// (R2) Drive state unchanged until identification completes
// (R3) Cancelled identification raises error code FF13
// (R4) Host starts only when ready, fault free
// (R5) Host keeps motor at standstill first
// (R6) Fixed pulse pattern to max current, measured
// (R7) Pole computed from currents, inverter then disabled
// (R8) Host: disable, mode 7, then enable
// (R9) Inhibit aborts without touching stored settings
// (R10) Success inhibits and stores pole position
// (R11) Control word clears automatic disable, re-enable allowed
// (R12) Execution setting writable only while inhibited
// (R13) Execution 0 off, 1 first/breakage, 2 always
// (R14) Host sets open-circuit response to fault
// (R15) Host sets breakage response to warning
// (R16) Host brings drive to switched-on, error free
`timescale 1ns/100ps
module spp_pole_ident
  import spp_pkg::*;
#(
  parameter int          CUR_W     = 12,
  parameter logic [11:0] IMAX      = 12'hF00,
  parameter int          PULSE_MAX = PULSE_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [15:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [CUR_W-1:0] cur_mag,
  input  wire logic             enc_wire_break,
  output logic                  inv_enable,
  output logic                  op_enabled,
  output logic      [2:0]       phase_hi,
  output logic      [2:0]       phase_lo,
  output logic                  irq
);
  if (PULSE_MAX < 2 || PULSE_MAX > 65535 || CUR_W != 12) begin : g_chk
    $error("spp_pole_ident: unsupported parameter values");
  end

  // Registers and state
  spp_state_t         state;
  spp_state_t         next_state;
  logic               ctrl_en;
  logic               auto_dis;
  logic [7:0]         mode;
  logic [7:0]         exec;
  logic [15:0]        pole;
  logic [15:0]        err_code;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic               ident_valid;
  logic               by_mode;
  logic               en_q;
  logic               brk_q;
  logic [2:0]         vec;
  logic [15:0]        cnt;
  logic [2:0]         best_idx;
  logic [CUR_W-1:0]   cur_s;
  logic               brk_s;

  // Pin inputs cross into pclk through two flops
  spp_sync #(.W(CUR_W + 1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({enc_wire_break, cur_mag}),
    .q       ({brk_s, cur_s})
  );

  // Vector pattern: high side of each phase; the low side is its complement
  function automatic logic [2:0] vec_hi(input logic [2:0] v);
    case (v)
      3'h0:    vec_hi = 3'h1;
      3'h1:    vec_hi = 3'h3;
      3'h2:    vec_hi = 3'h2;
      3'h3:    vec_hi = 3'h6;
      3'h4:    vec_hi = 3'h4;
      default: vec_hi = 3'h5;
    endcase
  endfunction : vec_hi

  // Bus decode
  wire        acc      = psel & penable;
  wire        rd_fire  = acc & ~pready;
  wire        wr_fire  = acc & pready & pwrite;
  wire        hit_ctrl = paddr == OFS_CTRL;
  wire        hit_mode = paddr == OFS_MODE;
  wire        hit_exec = paddr == OFS_EXEC;
  wire        hit_stat = paddr == OFS_STATUS;
  wire        hit_pole = paddr == OFS_POLE;
  wire        hit_isr  = paddr == OFS_IRQ_STAT;
  wire        hit_imr  = paddr == OFS_IRQ_MASK;
  wire        mapped   = hit_ctrl | hit_mode | hit_exec | hit_stat | hit_pole | hit_isr | hit_imr;
  wire        wr_ctrl  = wr_fire & hit_ctrl;
  wire        clr_dis  = wr_ctrl & pwdata[CTRL_CLR_BIT];
  wire        exec_ok  = ~inv_enable & (pwdata[7:0] <= EXEC_EVERY);                  // [R12]
  wire        wr_exec  = wr_fire & hit_exec & exec_ok;

  // Enable and launch conditions
  wire        en_eff   = ctrl_en & ~auto_dis;
  wire        en_rise  = en_eff & ~en_q;
  wire        busy     = (state == SPP_PULSE) | (state == SPP_DECAY) | (state == SPP_EVAL);
  wire        abort    = busy & ~en_eff;                                              // [R9]
  wire        brk_rise = brk_s & ~brk_q;
  wire        via_mode = mode == MODE_IDENT;
  wire        need_id  = via_mode | (exec == EXEC_EVERY)
                       | ((exec == EXEC_FIRST) & ~ident_valid);                       // [R13]
  wire        reached  = cur_s >= IMAX;                                               // [R6]
  wire        pulse_end = (state == SPP_PULSE) & (reached | (cnt == 16'(PULSE_MAX - 1)));
  wire        gap_end  = (state == SPP_DECAY) & (cnt == 16'(GAP_CYC - 1));
  wire        last_vec = vec == 3'(NUM_VEC - 1);
  wire        done     = (state == SPP_EVAL) & en_eff;
  wire [15:0] pole_new = 16'(best_idx * POLE_STEP);                                   // [R7]

  // Evaluation of the measured rise times
  spp_vector_eval #(.CW(16)) u_eval (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (en_rise),
    .sample   (pulse_end & en_eff),
    .idx      (vec),
    .rise_cyc (cnt),
    .best_idx (best_idx)
  );

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      SPP_IDLE: begin
        if (en_rise) begin
          next_state = need_id ? SPP_PULSE : SPP_RUN;
        end
      end
      SPP_PULSE: begin
        if (pulse_end) begin
          next_state = SPP_DECAY;
        end
      end
      SPP_DECAY: begin
        if (gap_end) begin
          next_state = last_vec ? SPP_EVAL : SPP_PULSE;
        end
      end
      SPP_EVAL: begin
        next_state = by_mode ? SPP_IDLE : SPP_RUN;                                    // [R1] [R7]
      end
      SPP_RUN: begin
        if (!en_eff) begin
          next_state = SPP_IDLE;
        end
      end
      default: next_state = SPP_IDLE;
    endcase
    if (abort) begin
      next_state = SPP_IDLE;
    end
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SPP_IDLE;
      en_q  <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      state <= next_state;
      en_q  <= en_eff;
      brk_q <= brk_s;
    end
  end

  // Pulse vector and its timer; counts restart per pulse and per gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec <= 3'h0;
      cnt <= 16'h0000;
    end else if (state == SPP_IDLE) begin
      vec <= 3'h0;
      cnt <= 16'h0000;
    end else if (pulse_end || gap_end) begin
      vec <= gap_end ? 3'(vec + 3'h1) : vec;
      cnt <= 16'h0000;
    end else begin
      cnt <= 16'(cnt + 16'h0001);
    end
  end

  // Power stage; phases go dark outside a pulse so the current can decay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_enable <= 1'b0;
      op_enabled <= 1'b0;
      phase_hi   <= 3'h0;
      phase_lo   <= 3'h0;
    end else begin
      inv_enable <= next_state != SPP_IDLE;                                          // [R1] [R10]
      op_enabled <= next_state == SPP_RUN;                                           // [R2]
      phase_hi   <= (next_state == SPP_PULSE) ? vec_hi(gap_end ? 3'(vec + 3'h1) : vec) : 3'h0;
      phase_lo   <= (next_state == SPP_PULSE) ? ~vec_hi(gap_end ? 3'(vec + 3'h1) : vec) : 3'h0;
    end
  end

  // Launch source, result, automatic disable and error code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      by_mode     <= 1'b0;
      auto_dis    <= 1'b0;
      pole        <= POLE_RST;
      err_code    <= ERR_NONE;
      ident_valid <= 1'b0;
    end else begin
      if (state == SPP_IDLE && en_rise && need_id) begin
        by_mode  <= via_mode;
        err_code <= ERR_NONE;
      end
      if (done) begin
        pole <= pole_new;                                                            // [R10]
      end
      if (abort) begin
        err_code <= ERR_CANCEL;                                                      // [R3]
      end
      if (done && by_mode) begin
        auto_dis <= 1'b1;                                                            // [R1] [R10]
      end else if (clr_dis) begin
        auto_dis <= 1'b0;                                                            // [R11]
      end
      if (brk_rise) begin
        ident_valid <= 1'b0;                                                         // [R13]
      end else if (done) begin
        ident_valid <= 1'b1;
      end
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en  <= 1'b0;
      mode     <= MODE_RST;
      exec     <= EXEC_OFF;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_en <= pwdata[CTRL_EN_BIT];
      end
      if (wr_fire && hit_mode) begin
        mode <= pwdata[7:0];
      end
      if (wr_exec) begin
        exec <= pwdata[7:0];                                                         // [R12]
      end
      if (wr_fire && hit_imr) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  wire [IRQ_W-1:0] irq_set = {brk_rise, abort, done};
  wire [IRQ_W-1:0] irq_clr = (wr_fire & hit_isr) ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq      <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // Read data selection
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_data = {30'h0, auto_dis, ctrl_en};
    end else if (hit_mode) begin
      rd_data = {24'h0, mode};
    end else if (hit_exec) begin
      rd_data = {24'h0, exec};
    end else if (hit_stat) begin
      rd_data = {err_code, 11'h0, ident_valid, auto_dis, inv_enable, op_enabled, busy};
    end else if (hit_pole) begin
      rd_data = {16'h0, pole};
    end else if (hit_isr) begin
      rd_data = {29'h0, irq_stat};
    end else if (hit_imr) begin
      rd_data = {29'h0, irq_mask};
    end
  end

  // One wait state: answer lands on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_fire;
      pslverr <= rd_fire & ~mapped;
      prdata  <= (rd_fire && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Checks
  a_cancel_code: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    abort |=> (err_code == ERR_CANCEL) && !inv_enable && irq_stat[IRQ_CANCEL])
    else $error("cancel did not raise the error code");

  a_state_held: assert property (@(posedge pclk) disable iff (!presetn)  // [R2]
    busy |-> !op_enabled)
    else $error("drive state changed during identification");

  a_auto_disable: assert property (@(posedge pclk) disable iff (!presetn)  // [R1]
    (done && by_mode) |=> !inv_enable && auto_dis ##1 !inv_enable)
    else $error("inverter not disabled after mode-launched run");

  a_exec_locked: assert property (@(posedge pclk) disable iff (!presetn)  // [R12]
    (wr_fire && hit_exec && inv_enable) |=> $stable(exec))
    else $error("execution setting changed while enabled");

  a_abort_keeps: assert property (@(posedge pclk) disable iff (!presetn)  // [R9]
    abort |=> $stable(pole) && $stable(mode) && $stable(exec))
    else $error("abort altered stored settings");

  a_pulse_bounded: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    (state == SPP_PULSE) |-> (cnt < 16'(PULSE_MAX)) && ((phase_hi ^ phase_lo) == 3'h7))
    else $error("test pulse overran or pattern broken");

  a_pole_stored: assert property (@(posedge pclk) disable iff (!presetn)  // [R10]
    done |=> pole == $past(pole_new))
    else $error("pole position not stored");

  a_clear_allows: assert property (@(posedge pclk) disable iff (!presetn)  // [R11]
    (clr_dis && !done) |=> !auto_dis)
    else $error("automatic disable not cleared");

  a_exec_select: assert property (@(posedge pclk) disable iff (!presetn)  // [R13]
    (state == SPP_IDLE && en_rise && exec == EXEC_EVERY) |=> state == SPP_PULSE)
    else $error("execution setting 2 did not launch identification");

endmodule : spp_pole_ident

// ### spp_pkg.sv
package spp_pkg;

  // Clock rate and the timing it drives
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned PULSE_US     = 200;                              // Longest test pulse
  localparam int unsigned PULSE_CYC    = PULSE_US * CLK_MHZ;               // Rounds down (exact here)
  localparam int unsigned GAP_NS       = 40;                               // Least decay gap between pulses
  localparam int unsigned GAP_CYC      = (GAP_NS * CLK_MHZ + 999) / 1000;  // Rounds up

  // Register byte addresses
  localparam logic [15:0] OFS_CTRL     = 16'h0000;
  localparam logic [15:0] OFS_MODE     = 16'h0004;
  localparam logic [15:0] OFS_STATUS   = 16'h0008;
  localparam logic [15:0] OFS_POLE     = 16'h000C;
  localparam logic [15:0] OFS_IRQ_STAT = 16'h0010;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h0014;
  localparam logic [15:0] EXEC_INDEX   = 16'h2C63;                         // Printed index, word address
  localparam logic [15:0] OFS_EXEC     = 16'(EXEC_INDEX * 4);

  // Field positions
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_CANCEL   = 1;
  localparam int unsigned IRQ_WIREBRK  = 2;
  localparam int unsigned IRQ_W        = 3;

  // Values and reset values
  localparam logic [7:0]  MODE_IDENT   = 8'h07;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [7:0]  EXEC_OFF     = 8'h00;
  localparam logic [7:0]  EXEC_FIRST   = 8'h01;
  localparam logic [7:0]  EXEC_EVERY   = 8'h02;
  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_CANCEL   = 16'hFF13;
  localparam logic [15:0] POLE_RST     = 16'h0000;
  localparam logic [15:0] POLE_STEP    = 16'h2AAB;                         // One sixth of a turn
  localparam int unsigned NUM_VEC      = 6;

  typedef enum logic [2:0] {
    SPP_IDLE  = 3'b000,
    SPP_PULSE = 3'b001,
    SPP_DECAY = 3'b010,
    SPP_EVAL  = 3'b011,
    SPP_RUN   = 3'b100
  } spp_state_t;

endpackage : spp_pkg

// ### spp_sync.sv
`timescale 1ns/100ps
module spp_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Two flops per bit; the first is read only by the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule : spp_sync

// ### spp_vector_eval.sv
`timescale 1ns/100ps
module spp_vector_eval #(
  parameter int CW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clear,
  input  wire logic          sample,
  input  wire logic [2:0]    idx,
  input  wire logic [CW-1:0] rise_cyc,
  output logic      [2:0]    best_idx
);
  logic [CW-1:0] best_cyc;
  wire           better = clear | (rise_cyc < best_cyc);

  // Shortest rise time marks the saturated axis, i.e. the magnet's north
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      best_cyc <= '1;
      best_idx <= 3'h0;
    end else if (sample && better) begin
      best_cyc <= rise_cyc;
      best_idx <= idx;
    end else if (clear) begin
      best_cyc <= '1;
    end
  end
endmodule : spp_vector_eval

// ### spp_motor_model.sv
`timescale 1ns/100ps
// Motor at standstill with a current sensor: current only follows the applied test vectors
module spp_motor_model #(
  parameter int          FAST_VEC  = 3,
  parameter logic [11:0] SLOW_STEP = 12'h100,
  parameter logic [11:0] FAST_STEP = 12'h300
) (
  input  wire logic        pclk,
  input  wire logic        inv_enable,
  input  wire logic [2:0]  phase_hi,
  output logic      [11:0] cur_mag
);
  logic [2:0]  pulse_no = 3'h0;
  logic        was_on   = 1'b0;
  logic [12:0] sum;
  logic [11:0] step;

  // Rotor alignment makes one vector rise fastest; the others saturate less quickly
  assign step = (pulse_no == 3'(FAST_VEC)) ? FAST_STEP : SLOW_STEP;
  assign sum  = {1'b0, cur_mag} + {1'b0, step};

  // Current ramps during a pulse and decays to zero in the gap; no motion, so no back EMF
  always @(posedge pclk) begin
    was_on <= |phase_hi;
    if (!inv_enable) begin
      pulse_no <= 3'h0;
    end else if (was_on && !(|phase_hi)) begin
      pulse_no <= pulse_no + 3'h1;
    end
    if (!(|phase_hi)) begin
      cur_mag <= 12'h000;
    end else begin
      cur_mag <= sum[12] ? 12'hFFF : sum[11:0];                 // Sensor clips at full scale
    end
  end
endmodule : spp_motor_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench import spp_pkg::*;;
  localparam int          FAST_VEC = 3;
  localparam logic [15:0] POLE_EXP = 16'(FAST_VEC * POLE_STEP);
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        enc_wire_break = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, inv_enable, op_enabled, irq, err_seen, on_d;
  logic [11:0] cur_mag;
  logic [2:0]  phase_hi, phase_lo;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  int          pulses     = 0;

  // Short pulse ceiling keeps the run brief; the model's slow vectors still reach the limit
  spp_pole_ident #(.PULSE_MAX(40)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_mag(cur_mag), .enc_wire_break(enc_wire_break), .inv_enable(inv_enable),
    .op_enabled(op_enabled), .phase_hi(phase_hi), .phase_lo(phase_lo), .irq(irq)
  );
  spp_motor_model #(.FAST_VEC(FAST_VEC)) motor (
    .pclk(pclk), .inv_enable(inv_enable), .phase_hi(phase_hi), .cur_mag(cur_mag)
  );

  always #2 pclk = ~pclk;

  // Hang guard and gate watcher; a pulse is counted at its first active cycle
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    on_d   <= |phase_hi;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
    if (presetn && phase_hi !== 3'b000) begin                                // Outputs are unknown before reset lands
      check({29'h0, phase_lo}, {29'h0, ~phase_hi}, "gate pair");
      check({31'h0, op_enabled}, 32'h0, "state during ident");
      if (!on_d) pulses++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] data);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  task automatic rdchk(input logic [15:0] addr, input logic [31:0] exp, input string msg);
    apb(1'b0, addr, 32'h0000_0000);
    check(rd, exp, msg);
  endtask : rdchk

  // Polls busy; the global guard ends a wait that never finishes
  task automatic wait_idle();
    do apb(1'b0, OFS_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
  endtask : wait_idle

  task automatic t_reset_values();
    rdchk(OFS_MODE, {24'h0, MODE_RST}, "mode reset");
    rdchk(OFS_STATUS, 32'h0000_0000, "status reset");
    rdchk(OFS_POLE, {16'h0, POLE_RST}, "pole reset");
    wr(OFS_POLE, 32'h0000_1234);
    rdchk(OFS_POLE, {16'h0, POLE_RST}, "pole read only");
    apb(1'b0, 16'h0020, 32'h0000_0000);
    check({31'h0, err_seen}, 32'h0000_0001, "unmapped slverr");
  endtask : t_reset_values

  task automatic t_mode_launch();
    wr(OFS_EXEC, {24'h0, EXEC_OFF});
    wr(OFS_MODE, {24'h0, MODE_IDENT});
    pulses = 0;
    wr(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    check(32'(pulses), 32'h0000_0006, "pulse count");
    check({31'h0, inv_enable}, 32'h0, "self disable");
    rdchk(OFS_POLE, {16'h0, POLE_EXP}, "pole value");
    rdchk(OFS_STATUS, 32'h0000_0018, "auto disable");
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(OFS_IRQ_MASK, 32'h0000_0007);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0001, "irq raised");
    rdchk(OFS_IRQ_STAT, 32'h0000_0001, "done event");
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_MODE, {24'h0, MODE_RST});
    pulses = 0;
    wr(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    check({30'h0, op_enabled, inv_enable}, 32'h0000_0003, "re-enabled");
    check(32'(pulses), 32'h0, "no ident when off");
  endtask : t_mode_launch

  task automatic t_exec_gate();
    wr(OFS_EXEC, {24'h0, EXEC_EVERY});
    rdchk(OFS_EXEC, {24'h0, EXEC_OFF}, "exec locked");
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_EXEC, 32'h0000_0003);
    rdchk(OFS_EXEC, {24'h0, EXEC_OFF}, "exec range");
    wr(OFS_EXEC, {24'h0, EXEC_EVERY});
    rdchk(OFS_EXEC, {24'h0, EXEC_EVERY}, "exec written");
  endtask : t_exec_gate

  task automatic t_abort_every();
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    wr(OFS_CTRL, 32'h0000_0000);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check({16'h0, rd[31:16]}, {16'h0, ERR_CANCEL}, "cancel code");
    check({31'h0, inv_enable}, 32'h0, "abort disables");
    rdchk(OFS_POLE, {16'h0, POLE_EXP}, "pole kept");
    rdchk(OFS_EXEC, {24'h0, EXEC_EVERY}, "exec kept");
    rdchk(OFS_IRQ_STAT, 32'h0000_0002, "cancel event");
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    pulses = 0;
    wr(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    check(32'(pulses), 32'h0000_0006, "ident every enable");
    check({30'h0, op_enabled, inv_enable}, 32'h0000_0003, "run after");
    wr(OFS_CTRL, 32'h0000_0000);
  endtask : t_abort_every

  task automatic t_exec_first();
    wr(OFS_EXEC, {24'h0, EXEC_FIRST});
    pulses = 0;
    wr(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    check(32'(pulses), 32'h0, "valid, no ident");
    check({31'h0, op_enabled}, 32'h0000_0001, "straight to run");
    wr(OFS_CTRL, 32'h0000_0000);
    enc_wire_break <= 1'b1;
    repeat (4) @(posedge pclk);
    enc_wire_break <= 1'b0;
    repeat (4) @(posedge pclk);
    rdchk(OFS_IRQ_STAT, 32'h0000_0005, "break event");                       // Done from the last identification run (t_abort_every) is still pending
    pulses = 0;
    wr(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    check(32'(pulses), 32'h0000_0006, "ident after break");
    rdchk(OFS_POLE, {16'h0, POLE_EXP}, "pole again");
    wr(OFS_CTRL, 32'h0000_0000);
  endtask : t_exec_first

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // Reset, then the scenarios in order; all but t_mode_launch leave the drive disabled
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_values();
    t_mode_launch();
    t_exec_gate();
    t_abort_every();
    t_exec_first();
    summarize();
  end
endmodule : testbench
